// File: shared/pcb_pkg.sv
// constants shared by the pci target bridge and its window decoder
package pcb_pkg;

	localparam int         DEC_N      = 4;
	localparam int         ATTR_W     = 6;
	localparam int         ATTR_RD    = 0;
	localparam int         ATTR_WR    = 1;
	localparam int         ATTR_POST  = 2;
	localparam int         ATTR_PREF  = 3;
	localparam int         ATTR_XFER  = 4;
	localparam int         IOB_EN     = 16;
	localparam int         STAT_W     = 3;
	localparam int         STAT_APE   = 0;
	localparam int         STAT_DPE   = 1;
	localparam int         STAT_IOBE  = 2;
	localparam int         LINE_LSB   = 5;

	localparam logic [15:0] CMD_CLAIM = 16'hdccc;

	localparam logic [7:0] REG_RANGE0 = 8'h00;
	localparam logic [7:0] REG_XLAT0  = 8'h10;
	localparam logic [7:0] REG_STEP   = 8'h04;
	localparam logic [7:0] REG_STAT   = 8'h20;
	localparam logic [7:0] REG_IOBASE = 8'h24;

	localparam logic [1:0] SP_MEM     = 2'h0;
	localparam logic [1:0] SP_IO      = 2'h1;
	localparam logic [1:0] SP_CFG     = 2'h2;

	localparam logic [31:0] STEP32    = 32'h4;
	localparam logic [31:0] STEP64    = 32'h8;

	typedef enum logic [2:0] {ST_IDLE, ST_DEC, ST_DATA, ST_STOPW, ST_TURN} pcb_state_t;
	typedef enum logic [1:0] {BT_ISSUE, BT_WAIT, BT_XFER} pcb_beat_t;

endpackage : pcb_pkg

// File: core/pcb_decoder.sv
// prioritised inbound window decoder with offset translation
module pcb_decoder
	import pcb_pkg::*;
#(
	parameter int N = DEC_N
) (
	input  wire logic [15:0]              addr_hi,
	input  wire logic                     wr,
	input  wire logic [N-1:0][31:0]       rng,
	input  wire logic [N-1:0][15:0]       xlat,
	input  wire logic [N-1:0][ATTR_W-1:0] attr,
	output logic                          hit,
	output logic [15:0]                   xhi,
	output logic [ATTR_W-1:0]             hit_attr
);

	logic [N-1:0] match;

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_win
			// 64k granularity: only upper half compared, upper bound inclusive
			assign match[g] = (addr_hi >= rng[g][15:0]) && (addr_hi <= rng[g][31:16]) &&
				(wr ? attr[g][ATTR_WR] : attr[g][ATTR_RD]);
		end
	endgenerate

	always_comb begin
		hit      = 1'b0;
		xhi      = '0;
		hit_attr = '0;
		// walk from lowest priority so window 0 is applied last
		for (int i = N - 1; i >= 0; i--) begin
			if (match[i]) begin
				hit      = 1'b1;
				xhi      = addr_hi + xlat[i];
				hit_attr = attr[i];
			end
		end
	end

endmodule : pcb_decoder

// File: core/pcb_target.sv
// pci target side of the host bridge: decode, handshake, lock, parity, registers

module pcb_target
	import pcb_pkg::*;
#(
	parameter int N_DEC = DEC_N
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        frame_n,
	input  wire logic        irdy_n,
	input  wire logic        idsel,
	input  wire logic        lock_n,
	input  wire logic        req64_n,
	input  wire logic [63:0] ad_in,
	input  wire logic [7:0]  cbe_in,
	input  wire logic        par_in,
	input  wire logic        par64_in,
	output logic [63:0]      ad_out,
	output logic             ad_oe,
	output logic             ad64_oe,
	output logic             par_out,
	output logic             par64_out,
	output logic             par_oe,
	output logic             par64_oe,
	output logic             devsel_n,
	output logic             trdy_n,
	output logic             stop_n,
	output logic             ack64_n,
	output logic             tgt_oe,
	output logic             perr_n,
	output logic             perr_oe,
	output logic             serr_n,
	output logic             serr_oe,
	output logic             pb_req,
	output logic             pb_we,
	output logic             pb_post,
	output logic             pb_pref,
	output logic             pb_lock,
	output logic             pb_wide,
	output logic [1:0]       pb_space,
	output logic [31:0]      pb_addr,
	output logic [63:0]      pb_wdata,
	output logic [7:0]       pb_be,
	output logic [1:0]       pb_xfer,
	input  wire logic        pb_ready,
	input  wire logic        pb_done,
	input  wire logic        pb_rvalid,
	input  wire logic [63:0] pb_rdata,
	input  wire logic        pb_idle,
	input  wire logic        snp_valid,
	input  wire logic [31:0] snp_addr,
	output logic             snp_retry,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_we,
	input  wire logic        reg_re,
	output logic [31:0]      reg_rdata
);

	typedef struct packed {
		pcb_state_t                   st;
		pcb_beat_t                    bt;
		logic                         fr_q;
		logic [31:0]                  addr;
		logic                         wide;
		logic                         is_wr;
		logic                         cfg;
		logic                         io;
		logic                         retry;
		logic                         disc;
		logic                         lk_cand;
		logic                         lk_own;
		logic                         locked;
		logic                         unlocking;
		logic [31-LINE_LSB:0]         lk_line;
		logic                         apar_chk;
		logic                         apar_exp;
		logic                         dpar_chk;
		logic                         dpar_w64;
		logic                         dpar_exp;
		logic                         dpar64_exp;
		logic [63:0]                  ad_out;
		logic                         ad_oe;
		logic                         ad64_oe;
		logic                         par_out;
		logic                         par64_out;
		logic                         par_oe;
		logic                         par64_oe;
		logic                         devsel_n;
		logic                         trdy_n;
		logic                         stop_n;
		logic                         ack64_n;
		logic                         tgt_oe;
		logic                         perr_n;
		logic                         perr_oe;
		logic                         serr_n;
		logic                         serr_oe;
		logic                         pb_req;
		logic                         pb_we;
		logic                         pb_post;
		logic                         pb_pref;
		logic                         pb_lock;
		logic                         pb_wide;
		logic [1:0]                   pb_space;
		logic [31:0]                  pb_addr;
		logic [63:0]                  pb_wdata;
		logic [7:0]                   pb_be;
		logic [1:0]                   pb_xfer;
		logic                         snp_retry;
		logic [N_DEC-1:0][31:0]       rng;
		logic [N_DEC-1:0][15:0]       xlat;
		logic [N_DEC-1:0][ATTR_W-1:0] attr;
		logic [IOB_EN:0]              iobase;
		logic [STAT_W-1:0]            stat;
		logic [31:0]                  reg_rdata;
	} pcb_tgt_t;

	pcb_tgt_t            s_r;
	pcb_tgt_t            s_nxt;

	logic [15:0]         a_addr;
	logic                a_wr;
	logic                a_hit;
	logic [15:0]         a_xhi;
	logic [ATTR_W-1:0]   a_attr;
	logic [31:0]         nxt_addr;
	logic                b_hit;
	logic [3:0]          cmd;
	logic                is_cfg;
	logic                is_io;
	logic                tgt_hit;
	logic                addr_ph;
	logic                acc;
	logic                fin;
	logic                hole;
	logic [7:0]          en;
	logic [7:0]          fill;
	logic [3:0]          lowmask;
	logic [STAT_W-1:0]   st_set;
	logic [STAT_W-1:0]   st_clr;

	// window a decodes the address phase in idle or turn, else the current beat
	assign a_addr   = (s_r.st == ST_IDLE || s_r.st == ST_TURN) ? ad_in[31:16] : s_r.addr[31:16];
	assign a_wr     = (s_r.st == ST_IDLE || s_r.st == ST_TURN) ? cbe_in[0] : s_r.is_wr;
	assign nxt_addr = s_r.addr + (s_r.wide ? STEP64 : STEP32);

	pcb_decoder #(.N(N_DEC)) u_dec_cur (
		.addr_hi  (a_addr),
		.wr       (a_wr),
		.rng      (s_r.rng),
		.xlat     (s_r.xlat),
		.attr     (s_r.attr),
		.hit      (a_hit),
		.xhi      (a_xhi),
		.hit_attr (a_attr)
	);

	// second decoder looks one beat ahead so a window exit is seen in time
	pcb_decoder #(.N(N_DEC)) u_dec_nxt (
		.addr_hi  (nxt_addr[31:16]),
		.wr       (s_r.is_wr),
		.rng      (s_r.rng),
		.xlat     (s_r.xlat),
		.attr     (s_r.attr),
		.hit      (b_hit),
		.xhi      (),
		.hit_attr ()
	);

	always_comb begin
		s_nxt   = s_r;
		st_set  = '0;
		st_clr  = '0;
		cmd     = cbe_in[3:0];
		is_cfg  = (cmd[3:1] == 3'h5);
		is_io   = (cmd[3:1] == 3'h1);
		// address phase is any falling frame, also right after a last data phase
		addr_ph = !frame_n && s_r.fr_q;
		tgt_hit = CMD_CLAIM[cmd] && (is_cfg ? (idsel && ad_in[1:0] == 2'h0) :
			is_io ? (s_r.iobase[IOB_EN] && ad_in[31:16] == s_r.iobase[15:0]) : a_hit);
		acc     = s_r.pb_req && pb_ready;
		fin     = (s_r.pb_we && s_r.pb_post) ? acc :
			(!s_r.pb_req && (s_r.pb_we ? pb_done : pb_rvalid));
		en      = s_r.wide ? ~cbe_in : {4'h0, ~cbe_in[3:0]};
		fill    = en | (en - 8'h01);
		hole    = (en != 8'h00) && ((fill & (fill + 8'h01)) != 8'h00);
		lowmask = (4'h1 << s_r.addr[1:0]) - 4'h1;

		s_nxt.fr_q      = frame_n;
		s_nxt.serr_n    = 1'b1;
		s_nxt.serr_oe   = 1'b0;
		s_nxt.perr_n    = 1'b1;
		s_nxt.perr_oe   = !s_r.perr_n;
		s_nxt.reg_rdata = '0;
		s_nxt.apar_chk  = 1'b0;
		s_nxt.dpar_chk  = 1'b0;

		// read parity trails the driven data by one clock
		s_nxt.par_out   = ^{s_r.ad_out[31:0], cbe_in[3:0]};
		s_nxt.par64_out = ^{s_r.ad_out[63:32], cbe_in[7:4]};
		s_nxt.par_oe    = s_r.ad_oe;
		s_nxt.par64_oe  = s_r.ad64_oe;

		if (s_r.apar_chk && par_in != s_r.apar_exp) begin
			s_nxt.serr_n     = 1'b0;
			s_nxt.serr_oe    = 1'b1;
			st_set[STAT_APE] = 1'b1;
		end
		if (s_r.dpar_chk && (par_in != s_r.dpar_exp ||
			(s_r.dpar_w64 && par64_in != s_r.dpar64_exp))) begin
			s_nxt.perr_n     = 1'b0;
			s_nxt.perr_oe    = 1'b1;
			st_set[STAT_DPE] = 1'b1;
		end

		unique case (s_r.st)
			ST_IDLE: begin
				s_nxt.tgt_oe = 1'b0;
			end
			ST_DEC: begin
				if (s_r.apar_chk && par_in != s_r.apar_exp) begin
					s_nxt.st = ST_IDLE;
				end else begin
					// second clock after the address: medium timing
					s_nxt.devsel_n = 1'b0;
					s_nxt.tgt_oe   = 1'b1;
					s_nxt.ack64_n  = !s_r.wide;
					s_nxt.ad_oe    = !s_r.is_wr;
					s_nxt.ad64_oe  = !s_r.is_wr && s_r.wide;
					s_nxt.lk_own   = s_r.lk_cand && !lock_n;
					if (s_r.retry) begin
						s_nxt.stop_n = 1'b0;
						s_nxt.st     = ST_STOPW;
					end else begin
						s_nxt.st = ST_DATA;
						s_nxt.bt = BT_ISSUE;
					end
				end
			end
			ST_DATA: begin
				unique case (s_r.bt)
					BT_ISSUE: begin
						// writes only start once the master shows its data with irdy; reads start at once
						if (!s_r.is_wr || !irdy_n) begin
							s_nxt.pb_req   = 1'b1;
							s_nxt.pb_we    = s_r.is_wr;
							s_nxt.pb_wide  = s_r.wide;
							s_nxt.pb_space = s_r.cfg ? SP_CFG : (s_r.io ? SP_IO : SP_MEM);
							s_nxt.pb_addr  = (s_r.cfg || s_r.io) ? s_r.addr :
								{a_xhi, s_r.addr[15:2], 2'h0};
							s_nxt.pb_post  = s_r.is_wr && !s_r.cfg && !s_r.io &&
								a_attr[ATTR_POST];
							s_nxt.pb_pref  = !s_r.is_wr && !s_r.cfg && !s_r.io &&
								a_attr[ATTR_PREF];
							s_nxt.pb_xfer  = a_attr[ATTR_XFER +: 2];
							s_nxt.pb_lock  = s_r.lk_own;
							s_nxt.pb_wdata = ad_in;
							// reads always fetch every lane of their width: 8'hff when wide, 8'h0f when narrow
							s_nxt.pb_be    = s_r.is_wr ? en : (s_r.wide ? 8'hff : 8'h0f);
							if (s_r.lk_own) begin
								s_nxt.lk_line = s_nxt.pb_addr[31:LINE_LSB];
							end
							s_nxt.disc = s_r.cfg ||
								(!s_r.io && s_r.addr[1:0] != 2'h0) ||
								(s_r.is_wr && hole) ||
								(!s_r.cfg && !s_r.io && !b_hit);
							if (s_r.io && !s_r.is_wr && (|(~cbe_in[3:0] & lowmask))) begin
								s_nxt.serr_n      = 1'b0;
								s_nxt.serr_oe     = 1'b1;
								st_set[STAT_IOBE] = 1'b1;
							end
							s_nxt.bt = BT_WAIT;
						end
					end
					BT_WAIT: begin
						if (acc) begin
							s_nxt.pb_req = 1'b0;
						end
						// posted: trdy as soon as there is room; else after completion
						if (fin) begin
							s_nxt.trdy_n = 1'b0;
							s_nxt.stop_n = !s_r.disc;
							s_nxt.bt     = BT_XFER;
							if (!s_r.pb_we) begin
								s_nxt.ad_out = s_r.wide ? pb_rdata : {32'h0, pb_rdata[31:0]};
							end
						end
					end
					BT_XFER: begin
						if (!irdy_n) begin
							s_nxt.trdy_n = 1'b1;
							if (s_r.is_wr) begin
								s_nxt.dpar_chk   = 1'b1;
								s_nxt.dpar_w64   = s_r.wide;
								s_nxt.dpar_exp   = ^{ad_in[31:0], cbe_in[3:0]};
								s_nxt.dpar64_exp = ^{ad_in[63:32], cbe_in[7:4]};
							end
							if (s_r.lk_own) begin
								s_nxt.locked = 1'b1;
							end
							if (frame_n) begin
								s_nxt.st       = ST_TURN;
								s_nxt.devsel_n = 1'b1;
								s_nxt.stop_n   = 1'b1;
								s_nxt.ack64_n  = 1'b1;
								s_nxt.ad_oe    = 1'b0;
								s_nxt.ad64_oe  = 1'b0;
								s_nxt.lk_own   = 1'b0;
							end else if (!s_r.stop_n) begin
								s_nxt.st = ST_STOPW;
							end else begin
								// no length limit: keep stepping through contiguous windows
								s_nxt.addr = nxt_addr;
								s_nxt.bt   = BT_ISSUE;
							end
						end
					end
					default: begin
						s_nxt.bt = BT_ISSUE;
					end
				endcase
			end
			ST_STOPW: begin
				// hold stop until the master drops frame, never a delayed completion
				if (frame_n) begin
					s_nxt.st       = ST_TURN;
					s_nxt.devsel_n = 1'b1;
					s_nxt.stop_n   = 1'b1;
					s_nxt.ack64_n  = 1'b1;
					s_nxt.ad_oe    = 1'b0;
					s_nxt.ad64_oe  = 1'b0;
					s_nxt.lk_own   = 1'b0;
				end
			end
			ST_TURN: begin
				// one clock driven high before release keeps the lines clean
				s_nxt.tgt_oe = 1'b0;
				s_nxt.st     = ST_IDLE;
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase

		if ((s_r.st == ST_IDLE || s_r.st == ST_TURN) && addr_ph) begin
			s_nxt.apar_chk = 1'b1;
			s_nxt.apar_exp = ^{ad_in[31:0], cbe_in[3:0]};
			if (tgt_hit) begin
				s_nxt.st      = ST_DEC;
				s_nxt.addr    = ad_in[31:0];
				s_nxt.is_wr   = cmd[0];
				s_nxt.cfg     = is_cfg;
				s_nxt.io      = is_io;
				s_nxt.wide    = !req64_n && !is_cfg && !is_io;
				s_nxt.lk_cand = lock_n;
				s_nxt.retry   = s_r.unlocking || (s_r.locked && !lock_n);
			end
		end

		// lock is gone on the pci side once frame and lock are both idle
		if (s_r.locked && lock_n && frame_n) begin
			s_nxt.locked    = 1'b0;
			s_nxt.unlocking = 1'b1;
		end
		if (s_r.unlocking && pb_idle && !s_r.pb_req && s_r.st == ST_IDLE) begin
			s_nxt.unlocking = 1'b0;
		end
		s_nxt.snp_retry = (s_r.locked || s_r.unlocking) && snp_valid &&
			(snp_addr[31:LINE_LSB] == s_r.lk_line);

		for (int i = 0; i < N_DEC; i++) begin
			if (reg_we && reg_addr == 8'(REG_RANGE0 + i * REG_STEP)) begin
				s_nxt.rng[i] = reg_wdata;
			end
			if (reg_we && reg_addr == 8'(REG_XLAT0 + i * REG_STEP)) begin
				s_nxt.xlat[i] = reg_wdata[15:0];
				s_nxt.attr[i] = reg_wdata[16 +: ATTR_W];
			end
			if (reg_re && reg_addr == 8'(REG_RANGE0 + i * REG_STEP)) begin
				s_nxt.reg_rdata = s_r.rng[i];
			end
			if (reg_re && reg_addr == 8'(REG_XLAT0 + i * REG_STEP)) begin
				s_nxt.reg_rdata = {10'h0, s_r.attr[i], s_r.xlat[i]};
			end
		end
		if (reg_we && reg_addr == REG_IOBASE) begin
			s_nxt.iobase = reg_wdata[IOB_EN:0];
		end
		if (reg_we && reg_addr == REG_STAT) begin
			st_clr = reg_wdata[STAT_W-1:0];
		end
		if (reg_re && reg_addr == REG_IOBASE) begin
			s_nxt.reg_rdata = {15'h0, s_r.iobase};
		end
		if (reg_re && reg_addr == REG_STAT) begin
			s_nxt.reg_rdata = {27'h0, s_r.unlocking, s_r.locked, s_r.stat};
		end
		// a new error in the clearing cycle survives
		s_nxt.stat = (s_r.stat & ~st_clr) | st_set;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_r          <= '0;
			s_r.fr_q     <= 1'b1;
			s_r.devsel_n <= 1'b1;
			s_r.trdy_n   <= 1'b1;
			s_r.stop_n   <= 1'b1;
			s_r.ack64_n  <= 1'b1;
			s_r.perr_n   <= 1'b1;
			s_r.serr_n   <= 1'b1;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign ad_out    = s_r.ad_out;
	assign ad_oe     = s_r.ad_oe;
	assign ad64_oe   = s_r.ad64_oe;
	assign par_out   = s_r.par_out;
	assign par64_out = s_r.par64_out;
	assign par_oe    = s_r.par_oe;
	assign par64_oe  = s_r.par64_oe;
	assign devsel_n  = s_r.devsel_n;
	assign trdy_n    = s_r.trdy_n;
	assign stop_n    = s_r.stop_n;
	assign ack64_n   = s_r.ack64_n;
	assign tgt_oe    = s_r.tgt_oe;
	assign perr_n    = s_r.perr_n;
	assign perr_oe   = s_r.perr_oe;
	assign serr_n    = s_r.serr_n;
	assign serr_oe   = s_r.serr_oe;
	assign pb_req    = s_r.pb_req;
	assign pb_we     = s_r.pb_we;
	assign pb_post   = s_r.pb_post;
	assign pb_pref   = s_r.pb_pref;
	assign pb_lock   = s_r.pb_lock;
	assign pb_wide   = s_r.pb_wide;
	assign pb_space  = s_r.pb_space;
	assign pb_addr   = s_r.pb_addr;
	assign pb_wdata  = s_r.pb_wdata;
	assign pb_be     = s_r.pb_be;
	assign pb_xfer   = s_r.pb_xfer;
	assign snp_retry = s_r.snp_retry;
	assign reg_rdata = s_r.reg_rdata;

endmodule : pcb_target

// File: verif/pcb_target_properties.sv
// port assertions for the pci target bridge
module pcb_checker (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        frame_n,
	input wire logic [7:0]  cbe_in,
	input wire logic [63:0] ad_out,
	input wire logic        ad_oe,
	input wire logic        par_out,
	input wire logic        par_oe,
	input wire logic        devsel_n,
	input wire logic        trdy_n,
	input wire logic        stop_n,
	input wire logic        tgt_oe,
	input wire logic        serr_n,
	input wire logic        serr_oe,
	input wire logic        pb_req,
	input wire logic        pb_ready,
	input wire logic        pb_done,
	input wire logic        pb_rvalid,
	input wire logic [31:0] pb_addr,
	input wire logic        snp_valid,
	input wire logic        snp_retry
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// driven high one cycle before letting go, so fast back-to-back sees a clean edge
	sequence s_release;
		tgt_oe ##1 !tgt_oe;
	endsequence
	sequence s_serr_pulse;
		serr_oe ##1 (serr_n && !serr_oe);
	endsequence
	a_devsel_medium: assert property ($fell(devsel_n) |-> $past(frame_n, 3) && !$past(frame_n, 2))
		else $error("devsel not medium timing");
	a_trdy_with_sel: assert property (!trdy_n |-> !devsel_n && tgt_oe)
		else $error("trdy without devsel");
	a_trdy_cause: assert property ($fell(trdy_n) |-> $past(pb_rvalid) || $past(pb_ready) || $past(pb_done))
		else $error("trdy before bus side finished");
	a_read_parity: assert property ($past(ad_oe) && par_oe |-> par_out == ^{$past(ad_out[31:0]), $past(cbe_in[3:0])})
		else $error("read parity wrong");
	a_serr_pulse: assert property ($fell(serr_n) |-> s_serr_pulse)
		else $error("serr not a one cycle pulse");
	a_stop_with_sel: assert property ($fell(stop_n) |-> !devsel_n && tgt_oe)
		else $error("stop without devsel");
	a_req_holds: assert property (pb_req && !pb_ready |=> pb_req && $stable(pb_addr))
		else $error("bus request dropped or changed");
	a_snoop_reply: assert property (snp_retry |-> $past(snp_valid))
		else $error("snoop retry without snoop");
	a_turn_release: assert property ($rose(devsel_n) |-> s_release)
		else $error("target signals not released");
endmodule : pcb_checker

bind pcb_target pcb_checker chk_u (.clock, .rst, .frame_n, .cbe_in, .ad_out, .ad_oe,
	.par_out, .par_oe, .devsel_n, .trdy_n, .stop_n, .tgt_oe, .serr_n, .serr_oe, .pb_req,
	.pb_ready, .pb_done, .pb_rvalid, .pb_addr, .snp_valid, .snp_retry);

// File: verif/pcb_pb_model.sv
// processor-bus side responder for the bridge bench
module pcb_pb_model (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        pb_req,
	input  wire logic        pb_we,
	input  wire logic        pb_post,
	input  wire logic [31:0] pb_addr,
	input  wire logic [63:0] pb_wdata,
	input  wire logic [1:0]  slow,
	output logic             pb_ready,
	output logic             pb_done,
	output logic             pb_rvalid,
	output logic [63:0]      pb_rdata,
	output logic             pb_idle,
	output logic [63:0]      last_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        busy;
	logic        we_r;
	logic        post_r;
	logic [1:0]  cnt;
	logic [31:0] a_r;

	assign pb_idle = !busy && !pb_req;

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
			pb_ready <= 1'b0;
			pb_done <= 1'b0;
			pb_rvalid <= 1'b0;
			pb_rdata <= 64'h0;
		end else begin
			pb_ready <= 1'b0;
			pb_done <= 1'b0;
			pb_rvalid <= 1'b0;
			// stale read data wiggles so it never passes for valid
			pb_rdata <= ~pb_rdata;
			if (!busy) begin
				if (pb_req && !pb_ready) begin
					pb_ready <= 1'b1;
					busy <= 1'b1;
					cnt <= slow;
					a_r <= pb_addr;
					we_r <= pb_we;
					post_r <= pb_post;
					last_wdata <= pb_wdata;
				end
			end else if (cnt != 2'h0) begin
				cnt <= cnt - 2'h1;
			end else begin
				busy <= 1'b0;
				pb_rvalid <= !we_r;
				pb_done <= we_r && !post_r;
				if (!we_r)
					pb_rdata <= {~a_r, a_r};
			end
		end
	end
endmodule : pcb_pb_model

// File: verif/test_pcb_target.sv
// self-checking bench for the pci target bridge
module test_pcb_target
	import pcb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	int          seed = 74069;
	int          err_count = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	bit          sel, stp, trd, ser;
	logic        clock = 1'b0, rst = 1'b1, frame_n = 1'b1, irdy_n = 1'b1, idsel = 1'b0;
	logic        lock_n = 1'b1, m_par = 1'b0, bad_par = 1'b0, snp_valid = 1'b0;
	logic        reg_we = 1'b0, reg_re = 1'b0;
	logic [1:0]  slow = 2'h0;
	logic [7:0]  cbe_in = 8'hff, reg_addr = 8'h0;
	logic [31:0] m_ad = 32'h0, snp_addr = 32'h0, reg_wdata = 32'h0, rd, w, a;
	logic [63:0] ad_in, ad_out, pb_wdata, pb_rdata, last_wdata;
	logic [31:0] pb_addr, reg_rdata;
	logic        ad_oe, par_in, par_out, par_oe, devsel_n, trdy_n, stop_n, tgt_oe, serr_n;
	logic        serr_oe, pb_req, pb_we, pb_post, pb_ready, pb_done, pb_rvalid, pb_idle;
	logic        snp_retry;

	// resolved wires: whoever has the enable drives the line
	assign ad_in = {32'h0, ad_oe ? ad_out[31:0] : m_ad};
	assign par_in = par_oe ? par_out : m_par;

	pcb_target dut_u (.clock, .rst, .ce(1'b1), .frame_n, .irdy_n, .idsel, .lock_n,
		.req64_n(1'b1), .ad_in, .cbe_in, .par_in, .par64_in(1'b0), .ad_out, .ad_oe,
		.ad64_oe(), .par_out, .par64_out(), .par_oe, .par64_oe(), .devsel_n, .trdy_n,
		.stop_n, .ack64_n(), .tgt_oe, .perr_n(), .perr_oe(), .serr_n, .serr_oe, .pb_req,
		.pb_we, .pb_post, .pb_pref(), .pb_lock(), .pb_wide(), .pb_space(), .pb_addr,
		.pb_wdata, .pb_be(), .pb_xfer(), .pb_ready, .pb_done, .pb_rvalid, .pb_rdata,
		.pb_idle, .snp_valid, .snp_addr, .snp_retry, .reg_addr, .reg_wdata, .reg_we,
		.reg_re, .reg_rdata);
	pcb_pb_model pbm_u (.clock, .rst, .pb_req, .pb_we, .pb_post, .pb_addr, .pb_wdata,
		.slow, .pb_ready, .pb_done, .pb_rvalid, .pb_rdata, .pb_idle, .last_wdata);

	always #20 clock = ~clock;
	always @(posedge clock) begin
		m_par <= ^{m_ad, cbe_in[3:0]} ^ bad_par;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			finish_test;
		end
	end

	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test

	task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] ra, input logic [31:0] d);
		@(posedge clock);
		reg_we <= 1'b1;
		reg_addr <= ra;
		reg_wdata <= d;
		@(posedge clock);
		reg_we <= 1'b0;
	endtask : wr

	task automatic rdc(input string nm, input logic [7:0] ra, input logic [31:0] e);
		@(posedge clock);
		reg_re <= 1'b1;
		reg_addr <= ra;
		@(posedge clock);
		reg_re <= 1'b0;
		@(posedge clock);
		chk(nm, reg_rdata, e);
	endtask : rdc

	task automatic snoop(input logic [31:0] sa, input logic e);
		@(posedge clock);
		snp_valid <= 1'b1;
		snp_addr <= sa;
		@(posedge clock);
		snp_valid <= 1'b0;
		@(posedge clock);
		chk("snoop retry", snp_retry, e);
	endtask : snoop

	// one single-beat transfer; a master abort gives up after five idle cycles
	task automatic xfer(input logic [3:0] c, input logic [31:0] ta, input logic [3:0] be,
		input logic [31:0] d, input bit lk);
		sel = 0;
		stp = 0;
		trd = 0;
		ser = 0;
		@(posedge clock);
		frame_n <= 1'b0;
		m_ad <= ta;
		cbe_in <= {4'hf, c};
		idsel <= (c[3:1] == 3'b101);
		slow <= 2'($random(seed));
		@(posedge clock);
		frame_n <= 1'b1;
		irdy_n <= 1'b0;
		cbe_in <= {4'hf, be};
		m_ad <= c[0] ? d : ~ta;
		if (lk)
			lock_n <= 1'b0;
		for (int n = 0; n < 24; n++) begin
			@(posedge clock);
			sel |= !devsel_n;
			stp |= !stop_n;
			ser |= !serr_n;
			if (!trdy_n) begin
				trd = 1;
				rd = ad_in[31:0];
			end
			if (!trdy_n || !stop_n || (n == 4 && !sel))
				break;
		end
		irdy_n <= 1'b1;
		m_ad <= ~m_ad;
		repeat (3) @(posedge clock);
	endtask : xfer

	initial begin
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		rdc("status", REG_STAT, 32'h0);
		rdc("range", REG_RANGE0, 32'h0);
		wr(REG_RANGE0, 32'h1000_1000);
		wr(REG_XLAT0, 32'h0007_0010);
		wr(REG_RANGE0 + REG_STEP, 32'h2000_1000);
		wr(REG_XLAT0 + REG_STEP, 32'h0003_0200);
		wr(REG_IOBASE, 32'h0001_3000);
		wr(8'hfc, 32'hffff_ffff);
		rdc("xlat1", REG_XLAT0 + REG_STEP, 32'h0003_0200);
		rdc("unmapped", 8'hfc, 32'h0);
		$display("test registers done");
		for (int c = 0; c < 16; c++) begin
			a = (c[3:1] == 3'b001) ? 32'h3000_0000 : 32'h1000_0040;
			w = $random(seed);
			xfer(4'(c), a, c[0] ? 4'h0 : 4'he, w, 1'b0);
			chk("claim", sel, CMD_CLAIM[c]);
			chk("cfg stop", stp, sel && c[3:1] == 3'b101);
			if (sel && c[0])
				chk("wdata", last_wdata[31:0], w);
			if (sel && !c[0] && c[2])
				chk("rdata", rd, 32'h1010_0040);
		end
		$display("test commands done");
		for (int i = 0; i < 8; i++) begin
			a = {16'h1001 + 16'(i * 16'h01ff), 14'($random(seed)), 2'h0};
			w = $random(seed);
			xfer(4'h7, a, 4'h0, w, 1'b0);
			chk("nonposted", last_wdata[31:0], w);
			xfer(4'h6, a, 4'h0, w, 1'b0);
			chk("xlat read", rd, {a[31:16] + 16'h0200, a[15:0]});
		end
		xfer(4'h6, 32'h2000_fffc, 4'h0, 32'h0, 1'b0);
		chk("window end", sel, 1'b1);
		xfer(4'h6, 32'h2001_0000, 4'h0, 32'h0, 1'b0);
		chk("past end", sel, 1'b0);
		xfer(4'h7, 32'h1000_0040, 4'ha, 32'h0, 1'b0);
		chk("hole stop", stp & trd, 1'b1);
		xfer(4'h6, 32'h1000_0041, 4'h0, 32'h0, 1'b0);
		chk("order stop", stp & trd, 1'b1);
		$display("test windows done");
		xfer(4'h2, 32'h3000_0002, 4'he, 32'h0, 1'b0);
		chk("io serr", ser, 1'b1);
		rdc("io status", REG_STAT, 32'h4);
		bad_par <= 1'b1;
		xfer(4'h6, 32'h1000_0040, 4'h0, 32'h0, 1'b0);
		bad_par <= 1'b0;
		chk("addr parity", {sel, ser}, 2'b01);
		rdc("par status", REG_STAT, 32'h5);
		wr(REG_STAT, 32'h7);
		rdc("cleared", REG_STAT, 32'h0);
		$display("test errors done");
		xfer(4'h6, 32'h1000_0040, 4'h0, 32'h0, 1'b1);
		snoop(32'h1010_005c, 1'b1);
		snoop(32'h1010_0060, 1'b0);
		xfer(4'h6, 32'h1800_0000, 4'h0, 32'h0, 1'b0);
		chk("lock retry", {sel, stp, trd}, 3'b110);
		rdc("lock status", REG_STAT, 32'h8);
		lock_n <= 1'b1;
		// unlock pends for a cycle; an access inside that gap is retried
		rdc("unlocking", REG_STAT, 32'h10);
		xfer(4'h6, 32'h1800_0000, 4'h0, 32'h0, 1'b0);
		chk("after unlock", trd, 1'b1);
		snoop(32'h1010_005c, 1'b0);
		$display("test lock done");
		finish_test;
	end
endmodule : test_pcb_target
